/* hw/spims_defines.svh */
// register map, field positions, reset values and divisors of the serial port
`ifndef SPIMS_DEFINES_SVH
`define SPIMS_DEFINES_SVH
`define SPIMS_OFS_CTRL 8'h10
`define SPIMS_OFS_STAT 8'h11
`define SPIMS_OFS_DATA 8'h12
// control register fields
`define SPIMS_C_RXIE 7
`define SPIMS_C_MSTR 5
`define SPIMS_C_CLOCK_IDLE_POLARITY 4
`define SPIMS_C_CLOCK_PHASE_SELECT 3
`define SPIMS_C_WOR 2
`define SPIMS_C_EN 1
`define SPIMS_C_TXIE 0
// status and control register fields
`define SPIMS_S_RXF 7
`define SPIMS_S_ERROR_IRQ_EN 6
`define SPIMS_S_OVR 5
`define SPIMS_S_MODE_FAULT_FLAG 4
`define SPIMS_S_TXE 3
`define SPIMS_S_FEN 2
`define SPIMS_RST_CTRL 8'h28
`define SPIMS_RST_STAT 8'h08
// master baud divisors for rate codes 00..11
`define SPIMS_BD_00 8'h02
`define SPIMS_BD_01 8'h08
`define SPIMS_BD_10 8'h20
`define SPIMS_BD_11 8'h80
// clock cycles in a half period of the far master clock
`define SPIMS_PEER_HALF 8'h10
`define SPIMS_LAST_EDGE 4'hf
`endif

/* hw/spims_dev.sv */
// serial port device end: registers, select pin handling and shift engine
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "spims_defines.svh"
module spims_dev (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic irq_tx,
    output logic irq_rx,
    output logic irq_err,
    output logic ss_gpio_mode,
    spims_if.dev link
);
    import spims_pkg::*;

    // reset words held as constants so single fields can be picked out
    localparam logic [7:0] RST_CTRL = `SPIMS_RST_CTRL;
    localparam logic [7:0] RST_STAT = `SPIMS_RST_STAT;

    logic rx_ie_ff, mstr_ff, clock_idle_polarity_ff, clock_phase_select_ff, wor_ff, en_ff, tx_ie_ff;
    logic err_ie_ff, fault_en_ff;
    logic [1:0] rate_ff;
    logic rx_full_ff, ovr_ff, mode_fault_flag_ff, tx_empty_ff;
    logic rx_arm_ff, ovr_arm_ff, mode_fault_flag_arm_ff;
    logic [7:0] txbuf_ff, rxbuf_ff, sh_ff, rdata_ff;
    logic out_ff, sclk_ff;
    logic [3:0] cnt_ff;
    logic [6:0] div_ff;
    spims_state_e st_ff;
    logic [1:0] sclk_s_ff, mosi_s_ff, miso_s_ff, ss_s_ff;
    logic sclk_d_ff, ss_d_ff;
    logic wr_ctrl, wr_stat, wr_data, rd_stat, rd_data;
    logic act_m, act_s, ss_lo, ss_fell, ss_rose;
    logic tick, lead, trail, samp, drv, last, start, in_bit, mode_fault_flag_set;
    logic [7:0] bd, byte_in;

    // address decode of the plain register port
    always_comb begin
        wr_ctrl = 1'b0;
        wr_stat = 1'b0;
        wr_data = 1'b0;
        rd_stat = 1'b0;
        rd_data = 1'b0;
        if (reg_addr == `SPIMS_OFS_CTRL) begin
            wr_ctrl = reg_wr;
        end else if (reg_addr == `SPIMS_OFS_STAT) begin
            wr_stat = reg_wr;
            rd_stat = reg_rd;
        end else if (reg_addr == `SPIMS_OFS_DATA) begin
            wr_data = reg_wr;
            rd_data = reg_rd;
        end
    end

    // pin synchronisers; the second stage and, for clock and select, its delayed copy are looked at
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sclk_s_ff <= 2'b00;
            mosi_s_ff <= 2'b11;
            miso_s_ff <= 2'b11;
            ss_s_ff <= 2'b11;
            sclk_d_ff <= 1'b0;
            ss_d_ff <= 1'b1;
        end else begin
            sclk_s_ff <= {sclk_s_ff[0], link.sclk};
            mosi_s_ff <= {mosi_s_ff[0], link.mosi};
            miso_s_ff <= {miso_s_ff[0], link.miso};
            ss_s_ff <= {ss_s_ff[0], link.ss_n};
            sclk_d_ff <= sclk_s_ff[1];
            ss_d_ff <= ss_s_ff[1];
        end
    end

    assign act_m = en_ff & mstr_ff;
    assign act_s = en_ff & ~mstr_ff;
    assign ss_lo = ~ss_s_ff[1];
    assign ss_fell = ss_d_ff & ~ss_s_ff[1];
    assign ss_rose = ~ss_d_ff & ss_s_ff[1];

    always_comb begin
        case (rate_ff)
            2'b00: bd = `SPIMS_BD_00;
            2'b01: bd = `SPIMS_BD_01;
            2'b10: bd = `SPIMS_BD_10;
            default: bd = `SPIMS_BD_11;
        endcase
    end

    always_comb begin
        tick = act_m && st_ff == spims_xfer && div_ff == 7'h00;
        if (act_m) begin
            lead = tick & (sclk_ff == clock_idle_polarity_ff);
            trail = tick & (sclk_ff != clock_idle_polarity_ff);
        end else begin
            lead = act_s & ss_lo & (sclk_s_ff[1] ^ sclk_d_ff) & (sclk_s_ff[1] != clock_idle_polarity_ff);
            trail = act_s & ss_lo & (sclk_s_ff[1] ^ sclk_d_ff) & (sclk_s_ff[1] == clock_idle_polarity_ff);
        end
        // phase picks sample and drive edges
        samp = clock_phase_select_ff ? trail : lead;
        drv = clock_phase_select_ff ? lead : trail;
        in_bit = mstr_ff ? miso_s_ff[1] : mosi_s_ff[1];
        last = st_ff == spims_xfer && (lead | trail) && cnt_ff == `SPIMS_LAST_EDGE;
        byte_in = clock_phase_select_ff ? {sh_ff[6:0], in_bit} : sh_ff;
        start = st_ff == spims_idle && ((act_m && !tx_empty_ff)
                || (act_s && ss_lo && (clock_phase_select_ff || ss_fell)));
    end

    // mode fault conditions; ignored when detection off
    assign mode_fault_flag_set = fault_en_ff & ((act_m & ss_lo) | (act_s & st_ff == spims_xfer & ss_rose));

    // control bits; a master mode fault also switches the port off
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            {rx_ie_ff, mstr_ff, clock_idle_polarity_ff, clock_phase_select_ff} <= {RST_CTRL[7], RST_CTRL[5:3]};
            {wor_ff, en_ff, tx_ie_ff} <= RST_CTRL[2:0];
            err_ie_ff <= RST_STAT[`SPIMS_S_ERROR_IRQ_EN];
            fault_en_ff <= RST_STAT[`SPIMS_S_FEN];
            rate_ff <= RST_STAT[1:0];
        end else begin
            if (wr_ctrl) begin
                rx_ie_ff <= reg_wdata[`SPIMS_C_RXIE];
                mstr_ff <= reg_wdata[`SPIMS_C_MSTR];
                clock_idle_polarity_ff <= reg_wdata[`SPIMS_C_CLOCK_IDLE_POLARITY];
                clock_phase_select_ff <= reg_wdata[`SPIMS_C_CLOCK_PHASE_SELECT];
                wor_ff <= reg_wdata[`SPIMS_C_WOR];
                en_ff <= reg_wdata[`SPIMS_C_EN];
                tx_ie_ff <= reg_wdata[`SPIMS_C_TXIE];
            end
            if (mode_fault_flag_set && act_m) begin
                en_ff <= 1'b0;
            end
            if (wr_stat) begin
                err_ie_ff <= reg_wdata[`SPIMS_S_ERROR_IRQ_EN];
                fault_en_ff <= reg_wdata[`SPIMS_S_FEN];
                rate_ff <= reg_wdata[1:0];
            end
        end
    end

    // shift engine, held in partial reset while disabled
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= spims_idle;
            cnt_ff <= 4'h0;
            sh_ff <= 8'h00;
            out_ff <= 1'b0;
            sclk_ff <= 1'b0;
            div_ff <= 7'h00;
        end else if (!en_ff) begin
            st_ff <= spims_idle;
            cnt_ff <= 4'h0;
            sh_ff <= 8'h00;
            sclk_ff <= clock_idle_polarity_ff;
            div_ff <= 7'h00;
        end else begin
            case (st_ff)
                spims_xfer: begin
                    if (tick) begin
                        div_ff <= bd[7:1] - 7'h01;
                        sclk_ff <= ~sclk_ff;
                    end else begin
                        div_ff <= div_ff - 7'h01;
                    end
                    if (samp) begin
                        sh_ff <= {sh_ff[6:0], in_bit};
                    end
                    if (drv) begin
                        out_ff <= sh_ff[7];
                    end
                    if (lead || trail) begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end
                    // deselect aborts a byte in flight
                    if ((act_s && !ss_lo) || last) begin
                        st_ff <= spims_idle;
                    end
                end
                default: begin
                    sclk_ff <= clock_idle_polarity_ff;
                    cnt_ff <= 4'h0;
                    if (start) begin
                        sh_ff <= txbuf_ff;
                        out_ff <= txbuf_ff[7];
                        div_ff <= bd[7:1] - 7'h01;
                        st_ff <= spims_xfer;
                    end
                end
            endcase
        end
    end

    // writes fill transmit buffer, reads come from receive buffer
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            txbuf_ff <= 8'h00;
            tx_empty_ff <= RST_STAT[`SPIMS_S_TXE];
        end else begin
            if (wr_data) begin
                txbuf_ff <= reg_wdata;
            end
            // load into shifter sets, write clears, set wins
            if (!en_ff || (start && !tx_empty_ff)) begin
                tx_empty_ff <= 1'b1;
            end else if (wr_data) begin
                tx_empty_ff <= 1'b0;
            end
        end
    end

    // receive flags with their two-step clears; a set always beats a clear
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rxbuf_ff <= 8'h00;
            rx_full_ff <= 1'b0;
            ovr_ff <= 1'b0;
            rx_arm_ff <= 1'b0;
            ovr_arm_ff <= 1'b0;
        end else begin
            // arm on status read, clear on data read
            if (last && !rx_full_ff) begin
                rxbuf_ff <= byte_in;
                rx_full_ff <= 1'b1;
            end else if (rd_data && rx_arm_ff) begin
                rx_full_ff <= 1'b0;
            end
            if (last && rx_full_ff) begin
                ovr_ff <= 1'b1;
            end else if (rd_data && ovr_arm_ff) begin
                ovr_ff <= 1'b0;
            end
            if (rd_data) begin
                rx_arm_ff <= 1'b0;
                ovr_arm_ff <= 1'b0;
            end else if (rd_stat) begin
                rx_arm_ff <= rx_arm_ff | rx_full_ff;
                ovr_arm_ff <= ovr_arm_ff | ovr_ff;
            end
        end
    end

    // only a set needs detection enabled
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mode_fault_flag_ff <= 1'b0;
            mode_fault_flag_arm_ff <= 1'b0;
        end else begin
            // status read then data write clears
            if (mode_fault_flag_set) begin
                mode_fault_flag_ff <= 1'b1;
            end else if (wr_data && mode_fault_flag_arm_ff) begin
                mode_fault_flag_ff <= 1'b0;
            end
            if (wr_data) begin
                mode_fault_flag_arm_ff <= 1'b0;
            end else if (rd_stat && mode_fault_flag_ff) begin
                mode_fault_flag_arm_ff <= 1'b1;
            end
        end
    end

    // read data registered, valid in the cycle after the read strobe
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `SPIMS_OFS_CTRL) begin
                rdata_ff <= {rx_ie_ff, 1'b0, mstr_ff, clock_idle_polarity_ff, clock_phase_select_ff, wor_ff, en_ff, tx_ie_ff};
            end else if (reg_addr == `SPIMS_OFS_STAT) begin
                rdata_ff <= {rx_full_ff, err_ie_ff, ovr_ff, mode_fault_flag_ff,
                             tx_empty_ff, fault_en_ff, rate_ff};
            end else if (reg_addr == `SPIMS_OFS_DATA) begin
                rdata_ff <= rxbuf_ff;
            end else begin
                rdata_ff <= 8'h00;
            end
        end else begin
            rdata_ff <= 8'h00;
        end
    end
    assign reg_rdata = rdata_ff;

    assign irq_rx = rx_full_ff & rx_ie_ff;
    assign irq_tx = tx_empty_ff & tx_ie_ff & en_ff;
    assign irq_err = err_ie_ff & (mode_fault_flag_ff | ovr_ff);
    // select pin free for general use
    assign ss_gpio_mode = ~en_ff | (mstr_ff & ~fault_en_ff);

    // wired-or drives only lows; released pins fall back to the pull-up
    assign link.dev_sclk_o = wor_ff ? 1'b0 : sclk_ff;
    assign link.dev_sclk_oe = act_m & (~wor_ff | ~sclk_ff);
    assign link.dev_mosi_o = wor_ff ? 1'b0 : out_ff;
    assign link.dev_mosi_oe = act_m & (~wor_ff | ~out_ff);
    assign link.dev_miso_o = wor_ff ? 1'b0 : out_ff;
    assign link.dev_miso_oe = act_s & ss_lo & (~wor_ff | ~out_ff);
endmodule // spims_dev
`default_nettype wire

/* hw/spims_if.sv */
// serial link between device end and far end, pins resolved with pull-ups
`timescale 1ns/1ps
`default_nettype none
interface spims_if;
    logic dev_sclk_o, dev_sclk_oe, dev_mosi_o, dev_mosi_oe, dev_miso_o, dev_miso_oe;
    logic peer_sclk_o, peer_sclk_oe, peer_mosi_o, peer_mosi_oe;
    logic peer_miso_o, peer_miso_oe, peer_ss_o, peer_ss_oe;
    logic sclk, mosi, miso, ss_n;
    // undriven wire pulls high; any driven low wins, as on an open-drain line
    assign sclk = (~dev_sclk_oe | dev_sclk_o) & (~peer_sclk_oe | peer_sclk_o);
    assign mosi = (~dev_mosi_oe | dev_mosi_o) & (~peer_mosi_oe | peer_mosi_o);
    assign miso = (~dev_miso_oe | dev_miso_o) & (~peer_miso_oe | peer_miso_o);
    assign ss_n = ~peer_ss_oe | peer_ss_o;
    modport dev (
        output dev_sclk_o, dev_sclk_oe, dev_mosi_o, dev_mosi_oe, dev_miso_o, dev_miso_oe,
        input sclk, mosi, miso, ss_n
    );
    modport peer (
        output peer_sclk_o, peer_sclk_oe, peer_mosi_o, peer_mosi_oe,
        output peer_miso_o, peer_miso_oe, peer_ss_o, peer_ss_oe,
        input sclk, mosi, miso, ss_n
    );
endinterface // spims_if
`default_nettype wire

/* hw/spims_peer.sv */
// far end of the serial link: simple master or slave shift engine
`timescale 1ns/1ps
`default_nettype none
`include "spims_defines.svh"
module spims_peer #(
    parameter logic [7:0] HALF = `SPIMS_PEER_HALF
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic is_master,
    input wire logic clock_idle_polarity,
    input wire logic clock_phase_select,
    input wire logic hold_ss,
    input wire logic start,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte,
    output logic done,
    output logic busy,
    spims_if.peer link
);
    import spims_pkg::*;

    logic [1:0] sclk_s_ff, mosi_s_ff, miso_s_ff, ss_s_ff;
    logic sclk_d_ff, ss_d_ff, sclk_ff, ss_ff, out_ff, done_ff;
    logic [7:0] sh_ff, rx_ff, div_ff;
    logic [3:0] cnt_ff;
    spims_state_e st_ff;
    logic ss_lo, sedge, tick, lead, trail, samp, drv, in_bit, last;

    // pin synchronisers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sclk_s_ff <= 2'b00;
            mosi_s_ff <= 2'b11;
            miso_s_ff <= 2'b11;
            ss_s_ff <= 2'b11;
            sclk_d_ff <= 1'b0;
            ss_d_ff <= 1'b1;
        end else begin
            sclk_s_ff <= {sclk_s_ff[0], link.sclk};
            mosi_s_ff <= {mosi_s_ff[0], link.mosi};
            miso_s_ff <= {miso_s_ff[0], link.miso};
            ss_s_ff <= {ss_s_ff[0], link.ss_n};
            sclk_d_ff <= sclk_s_ff[1];
            ss_d_ff <= ss_s_ff[1];
        end
    end

    // same polarity and phase as device
    always_comb begin
        ss_lo = ~ss_s_ff[1];
        sedge = ~is_master & ss_lo & (sclk_s_ff[1] ^ sclk_d_ff);
        tick = is_master && st_ff == spims_xfer && div_ff == 8'h00;
        lead = is_master ? tick & (sclk_ff == clock_idle_polarity) : sedge & (sclk_s_ff[1] != clock_idle_polarity);
        trail = is_master ? tick & (sclk_ff != clock_idle_polarity) : sedge & (sclk_s_ff[1] == clock_idle_polarity);
        samp = clock_phase_select ? trail : lead;
        drv = clock_phase_select ? lead : trail;
        in_bit = is_master ? miso_s_ff[1] : mosi_s_ff[1];
        last = st_ff == spims_xfer && (lead | trail) && cnt_ff == `SPIMS_LAST_EDGE;
    end

    // engine; a master end waits a half period before the first edge
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= spims_idle;
            sclk_ff <= 1'b0;
            ss_ff <= 1'b1;
            out_ff <= 1'b0;
            sh_ff <= 8'h00;
            rx_ff <= 8'h00;
            div_ff <= 8'h00;
            cnt_ff <= 4'h0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            case (st_ff)
                spims_xfer: begin
                    div_ff <= tick ? HALF - 8'h01 : div_ff - 8'h01;
                    if (tick) begin
                        sclk_ff <= ~sclk_ff;
                    end
                    if (samp) begin
                        sh_ff <= {sh_ff[6:0], in_bit};
                    end
                    if (drv) begin
                        out_ff <= sh_ff[7];
                    end
                    if (lead || trail) begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end
                    if (!is_master && !ss_lo) begin
                        st_ff <= spims_idle;
                    end else if (last) begin
                        done_ff <= 1'b1;
                        rx_ff <= clock_phase_select ? {sh_ff[6:0], in_bit} : sh_ff;
                        st_ff <= is_master ? spims_gap : spims_idle;
                        // select stays low past the last edge, else the slave drops it
                        div_ff <= {HALF[6:0], 1'b0} - 8'h01;
                    end
                end
                spims_gap: begin
                    // low for a half period, then high long enough to be seen
                    div_ff <= div_ff - 8'h01;
                    // phase 0 raises select between bytes
                    // phase 1 may hold select low
                    if (div_ff == HALF && (!clock_phase_select || !hold_ss)) begin
                        ss_ff <= 1'b1;
                    end
                    if (div_ff == 8'h00) begin
                        st_ff <= spims_idle;
                    end
                end
                default: begin
                    sclk_ff <= clock_idle_polarity;
                    cnt_ff <= 4'h0;
                    div_ff <= HALF - 8'h01;
                    if (!is_master) begin
                        ss_ff <= 1'b1;
                    end
                    if ((is_master && start) ||
                        (!is_master && ss_lo && (clock_phase_select || ss_fell_w(ss_d_ff, ss_s_ff[1])))) begin
                        sh_ff <= tx_byte;
                        out_ff <= tx_byte[7];
                        ss_ff <= ~is_master;
                        st_ff <= spims_xfer;
                    end
                end
            endcase
        end
    end

    function automatic logic ss_fell_w(input logic prev, input logic now);
        ss_fell_w = prev & ~now;
    endfunction

    assign rx_byte = rx_ff;
    assign done = done_ff;
    assign busy = st_ff != spims_idle;
    assign link.peer_sclk_o = sclk_ff;
    assign link.peer_sclk_oe = is_master;
    assign link.peer_mosi_o = out_ff;
    assign link.peer_mosi_oe = is_master;
    assign link.peer_ss_o = ss_ff;
    assign link.peer_ss_oe = is_master;
    assign link.peer_miso_o = out_ff;
    assign link.peer_miso_oe = ~is_master & ss_lo;
endmodule // spims_peer
`default_nettype wire

/* hw/spims_pkg.sv */
// types shared by both ends of the serial port
package spims_pkg;
    typedef enum logic [2:0] {
        spims_idle = 3'b001,
        spims_xfer = 3'b010,
        spims_gap = 3'b100
    } spims_state_e;
endpackage

/* testbench/spims_props.sv */
// link checker for the serial port
`timescale 1ns/1ps
`default_nettype none
module spims_props (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ss_gpio_mode,
    input wire logic dev_sclk_o,
    input wire logic dev_sclk_oe,
    input wire logic dev_mosi_oe,
    input wire logic dev_miso_oe,
    input wire logic peer_miso_oe,
    input wire logic ss_n
);
    logic [7:0] gap_ff;
    logic [3:0] edge_ff;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // cycles since the device clock moved, and its edges within the byte
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            gap_ff <= 8'h00;
            edge_ff <= 4'h0;
        end else if (!dev_sclk_oe) begin
            gap_ff <= 8'h00;
            edge_ff <= 4'h0;
        end else if ($changed(dev_sclk_o)) begin
            gap_ff <= 8'h01;
            edge_ff <= edge_ff + 4'h1;
        end else if (gap_ff != 8'h00 && gap_ff != 8'hff) begin
            gap_ff <= gap_ff + 8'h01;
        end
    end
    // first edge of a byte follows an idle gap of any length, so it is skipped
    a_sclk_half_period: assert property ($changed(dev_sclk_o) && edge_ff != 4'h0
        |-> gap_ff inside {8'h01, 8'h04, 8'h10, 8'h40})
        else $error("device clock half period off");
    a_dev_miso_float: assert property (ss_n && $past(ss_n) && $past(ss_n, 2)
        && $past(ss_n, 3) |-> !dev_miso_oe) else $error("deselected device drives data");
    a_peer_miso_float: assert property (ss_n && $past(ss_n) && $past(ss_n, 2)
        && $past(ss_n, 3) |-> !peer_miso_oe) else $error("deselected far end drives data");
    a_select_high_gap: assert property ($rose(ss_n) |-> ss_n [*6])
        else $error("select high too briefly");
    a_fault_drops_master: assert property ((dev_sclk_oe && !ss_gpio_mode && !ss_n) [*3]
        |-> ##[0:4] !dev_sclk_oe) else $error("master kept driving on fault");
    a_select_ignored: assert property (dev_sclk_oe && ss_gpio_mode && !ss_n
        |=> dev_sclk_oe) else $error("free select stopped master");
    a_slave_roles: assert property (dev_miso_oe |-> !dev_sclk_oe && !dev_mosi_oe)
        else $error("slave drives master pins");
    a_slave_select_input: assert property (dev_miso_oe |-> !ss_gpio_mode)
        else $error("slave select freed");
    c_fault: cover property ($fell(dev_sclk_oe) && !$past(ss_gpio_mode));
    c_slave: cover property (dev_miso_oe);
    c_frame: cover property ($rose(ss_n));
endmodule // spims_props
`default_nettype wire

/* testbench/spims_tb.sv */
// bench for the serial port: device end against far end
`timescale 1ns/1ps
`default_nettype none
module spims_tb;
    logic clock, rst_b, wr_s, rd_s, irq_tx, irq_rx, irq_err, gpio, clock_idle_polarity, clock_phase_select, start, pdone;
    logic pbusy;
    logic [7:0] addr, wdata, rdata, ptx, prx, v;
    int fails, samples_checked;
    spims_if lnk();
    spims_dev u_spims_dev (.clock(clock), .rst_b(rst_b), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata), .irq_tx(irq_tx), .irq_rx(irq_rx),
        .irq_err(irq_err), .ss_gpio_mode(gpio), .link(lnk));
    // short far clock keeps the run brief
    spims_peer #(.HALF(8'h08)) u_spims_peer (.clock(clock), .rst_b(rst_b), .is_master(1'b1),
        .clock_idle_polarity(clock_idle_polarity), .clock_phase_select(clock_phase_select), .hold_ss(1'b0), .start(start), .tx_byte(ptx),
        .rx_byte(prx), .done(pdone), .busy(pbusy), .link(lnk));
    spims_props u_spims_props (.clock(clock), .rst_b(rst_b), .ss_gpio_mode(gpio),
        .dev_sclk_o(lnk.dev_sclk_o), .dev_sclk_oe(lnk.dev_sclk_oe),
        .dev_mosi_oe(lnk.dev_mosi_oe), .dev_miso_oe(lnk.dev_miso_oe),
        .peer_miso_oe(lnk.peer_miso_oe), .ss_n(lnk.ss_n));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // a gap cycle after each strobe avoids assigning it twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clock);
        wr_s <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clock);
        rd_s <= 1'b0;
        @(negedge clock);
        d = rdata;
        @(posedge clock);
    endtask
    task automatic wait_stat(input logic [7:0] m);
        int n;
        n = 0;
        v = 8'h00;
        while ((v & m) !== m && n < 3000) begin
            rd(8'h11, v);
            n++;
        end
        chk(v & m, m);
    endtask
    // far end as master sends one byte
    task automatic go(input logic [7:0] d);
        int n;
        // the far master's select gap must run out first
        while (pbusy !== 1'b0) begin
            @(negedge clock);
        end
        @(posedge clock);
        ptx <= d;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        n = 0;
        while (pdone !== 1'b1 && n < 2000) begin
            @(negedge clock);
            n++;
        end
        chk({7'h00, pdone}, 8'h01);
        @(posedge clock);
    endtask
    task automatic reset_values();
        rd(8'h10, v);
        chk(v, 8'h28);
        rd(8'h11, v);
        chk(v, 8'h08);
        chk({4'h0, irq_tx, irq_rx, irq_err, gpio}, 8'h01);
        rd(8'h13, v);
        chk(v, 8'h00);
    endtask
    // device master on every rate; undriven return line reads all ones
    task automatic rates();
        logic s;
        int n;
        wr(8'h10, 8'hab);
        for (int c = 0; c < 4; c++) begin
            wr(8'h11, 8'(c));
            repeat (70) @(posedge clock);
            wr(8'h12, 8'h5a);
            for (int k = 0; k < 2; k++) begin
                s = lnk.dev_sclk_o;
                n = 0;
                while (lnk.dev_sclk_o === s && n < 300) begin
                    @(negedge clock);
                    n++;
                end
            end
            chk(8'(n), 8'h01 << (2 * c));
            @(posedge clock);
            wait_stat(8'h80);
            chk({6'h00, irq_rx, irq_tx}, 8'h03);
            rd(8'h12, v);
            chk(v, 8'hff);
            rd(8'h11, v);
            chk(v & 8'h80, 8'h00);
            chk({7'h00, irq_rx}, 8'h00);
        end
    endtask
    // device as slave takes two distinct bytes, so the kept one is visible
    task automatic overrun();
        clock_idle_polarity <= 1'b0;
        clock_phase_select <= 1'b1;
        wr(8'h11, 8'h43);
        wr(8'h10, 8'h0a);
        go(8'h81);
        wait_stat(8'h80);
        go(8'h42);
        wait_stat(8'h20);
        chk({7'h00, irq_err}, 8'h01);
        wr(8'h11, 8'h03);
        chk({7'h00, irq_err}, 8'h00);
        rd(8'h11, v);
        rd(8'h12, v);
        chk(v, 8'h81);
        rd(8'h11, v);
        chk(v, 8'h0b);
    endtask
    // far master collides with device master, first unguarded, then guarded
    task automatic mode_fault();
        wr(8'h10, 8'h3e);
        @(negedge clock);
        chk({6'h00, lnk.dev_sclk_oe, lnk.dev_sclk_o}, 8'h00);
        @(posedge clock);
        wr(8'h10, 8'h2a);
        chk({7'h00, gpio}, 8'h01);
        go(8'h96);
        rd(8'h10, v);
        chk(v, 8'h2a);
        wr(8'h11, 8'h07);
        chk({7'h00, gpio}, 8'h00);
        go(8'h96);
        rd(8'h10, v);
        chk(v, 8'h28);
        wr(8'h11, 8'h03);
        rd(8'h11, v);
        chk(v & 8'h10, 8'h10);
        wr(8'h12, 8'h00);
        rd(8'h11, v);
        chk(v & 8'h10, 8'h00);
    endtask
    task automatic slave_modes();
        for (int m = 0; m < 4; m++) begin
            clock_idle_polarity <= m[1];
            clock_phase_select <= m[0];
            wr(8'h10, {3'h0, m[1], m[0], 3'h2});
            rd(8'h11, v);
            chk(v & 8'h08, 8'h08);
            wr(8'h12, 8'h3c ^ 8'(m));
            go(8'ha5 + 8'(m));
            chk(prx, 8'h3c ^ 8'(m));
            wait_stat(8'h80);
            rd(8'h12, v);
            chk(v, 8'ha5 + 8'(m));
        end
    endtask
    task automatic conclude();
        if (fails == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // cut a hang short well past the expected three thousand or so cycles
    initial begin
        repeat (60000) @(posedge clock);
        fails++;
        conclude();
    end
    initial begin
        fails = 0;
        samples_checked = 0;
        {rst_b, wr_s, rd_s, clock_idle_polarity, clock_phase_select, start} = 6'h04;
        {addr, wdata, ptx} = 24'h000000;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        reset_values();
        rates();
        overrun();
        mode_fault();
        slave_modes();
        conclude();
    end
endmodule // spims_tb
`default_nettype wire
